// ==== bench/srd_primary_model.sv ====
// Primary PWM generator and filtered load comparator model
`timescale 1ns/1ps
module srd_primary_model
  import srd_pkg::*;
#(
  parameter logic [8:0] HALF = 9'h064,
  parameter logic [8:0] DEAD = 9'h01e
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic heavy,
  output logic      primaryPwmA,
  output logic      primaryPwmB,
  output logic      loadCompareEvent
);
  logic [9:0] cnt_q;
  logic [2:0] flt_q;
  // Period counter
  always_ff @(posedge clk) begin
    cnt_q <= (rst || !run || cnt_q >= {HALF, 1'b0} - 10'h1) ? 10'h0 : cnt_q + 10'h1;
  end
  // Dead time kept above the turn-off delay, as a shared counter needs
  assign primaryPwmA = run && cnt_q >= {1'b0, DEAD} && cnt_q < {1'b0, HALF};
  assign primaryPwmB = run && cnt_q >= {1'b0, HALF} + {1'b0, DEAD};
  // Filter: a new level must persist, so the enable cannot chatter
  always_ff @(posedge clk) begin
    flt_q            <= (rst || heavy == loadCompareEvent) ? 3'h0 : flt_q + 3'h1;
    loadCompareEvent <= rst ? 1'b0 : (flt_q == 3'h3) ? heavy : loadCompareEvent;
  end
endmodule

// ==== bench/srd_props.sv ====
// Port checker for the SR turn-off delay controller
`timescale 1ns/1ps
module srd_props
  import srd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        srPwmA,
  input wire logic        srPwmB,
  input wire logic [31:0] delayTileBus
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Transfer accepted by the slave
  wire logic taken = hsel && htrans[1] && hready && clkEn;
  // Read answer: one wait cycle, then ready
  sequence readWait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_MIRROR: assert property (delayTileBus[31:16] == delayTileBus[15:0])
    else $error("bus halves differ");
  AST_SPARE_LOW: assert property (delayTileBus[15:2] == 14'h0)
    else $error("spare bus bits set");
  AST_MATCH_PULSE: assert property (delayTileBus[0] && clkEn |=> !delayTileBus[0])
    else $error("match pulse too long");
  // Delayed edge clears the state, the drive follows one edge later
  AST_A_OFF: assert property (delayTileBus[0] && clkEn ##1 clkEn |=> !srPwmA)
    else $error("SR A on after delayed edge");
  AST_B_OFF: assert property (delayTileBus[1] && clkEn ##1 clkEn |=> !srPwmB)
    else $error("SR B on after delayed edge");
  AST_WR_NO_WAIT: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_RD_ONE_WAIT: assert property (taken && !hwrite |=> readWait)
    else $error("read wait wrong");
  AST_RDATA_HOLD: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data moved");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("error response");
  AST_FREEZE: assert property (!clkEn |=> $stable(srPwmA) && $stable(delayTileBus))
    else $error("moved while disabled");
  AST_RESET_OFF: assert property ($fell(rst) |-> !srPwmA && !srPwmB && hreadyout && delayTileBus == 32'h0)
    else $error("outputs busy after reset");
endmodule

// ==== bench/srd_sr_pwm_turnoff_delay_ctrl_bench.sv ====
// Self-checking bench for the SR turn-off delay controller
`timescale 1ns/1ps
module srd_sr_pwm_turnoff_delay_ctrl_bench;
  import srd_pkg::*;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        clkEn  = 1'b1;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        run    = 1'b0;
  logic        heavy  = 1'b0;
  logic [31:0] rd;
  logic [1:0]  seen;
  int          error_cnt  = 0;
  int          n_compared = 0;
  int          n;
  int          dly [2] = '{1, 25};
  wire logic        hreadyout, hresp, primaryPwmA, primaryPwmB, loadCompareEvent, srPwmA, srPwmB;
  wire logic [31:0] hrdata, delayTileBus;
  wire logic [3:0]  mon = {srPwmB, srPwmA, primaryPwmB, primaryPwmA};
  always #4 clk = ~clk;
  srd_sr_pwm_turnoff_delay_ctrl i_srd_sr_pwm_turnoff_delay_ctrl (.clk, .rst, .clkEn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .primaryPwmA,
    .primaryPwmB, .loadCompareEvent, .srPwmA, .srPwmB, .delayTileBus);
  srd_primary_model i_srd_primary_model (.clk, .rst, .run, .heavy, .primaryPwmA, .primaryPwmB, .loadCompareEvent);
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic waitReady;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk(32'h1, 32'h0, "bus hang");
      print_verdict();
    end
  endtask
  // Single word transfer; address held until accepted
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitReady();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string m);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask
  // Counts edges until a watched level appears
  task automatic waitLvl(input int i, input logic v);
    n = 0;
    while (mon[i] !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      chk(32'h1, 32'h0, "level hang");
      print_verdict();
    end
  endtask
  // Lag from primary fall to SR off, channel 0 is A
  task automatic lagChk(input int ch, input int lo, input int hi, input string m);
    waitLvl(ch, 1'b1);
    waitLvl(ch, 1'b0);
    waitLvl(ch + 2, 1'b0);
    chk({31'h0, n >= lo && n <= hi}, 32'h1, m);
  endtask
  task automatic quiet(input string m);
    seen = 2'h0;
    repeat (400) begin
      @(posedge clk);
      seen = seen | mon[3:2];
    end
    chk({30'h0, seen}, 32'h0, m);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdChk(OFF_CTRL, 32'h9, "ctrl");
    rdChk(OFF_DELAY, 32'd25, "delay");
    rdChk(OFF_SW_INPUTS, 32'h10, "gate");
    xfer(1'b1, OFF_CLAMP_REF, 32'h55);
    rdChk(OFF_CLAMP_REF, 32'h100, "clamp ro");
    rdChk(8'h20, 32'h0, "unmapped");
    run <= 1'b1;
    foreach (dly[k]) begin
      xfer(1'b1, OFF_DELAY, dly[k]);
      lagChk(0, dly[k] + 4, dly[k] + 4, "A lag");
      lagChk(1, dly[k] + 4, dly[k] + 4, "B lag");
    end
    xfer(1'b1, OFF_CTRL, 32'hd);
    lagChk(0, 26, 28, "A single");
    lagChk(1, 26, 28, "B single");
    xfer(1'b1, OFF_CTRL, 32'h1);
    lagChk(0, 2, 2, "A undelayed");
    // Closed gate must hold the old clamp across a period
    xfer(1'b1, OFF_SW_INPUTS, 32'h0);
    xfer(1'b1, OFF_GP_REG0, 32'd40);
    waitLvl(0, 1'b0);
    waitLvl(0, 1'b1);
    rdChk(OFF_CLAMP_REF, 32'h100, "gated");
    xfer(1'b1, OFF_SW_INPUTS, 32'h10);
    waitLvl(0, 1'b0);
    waitLvl(0, 1'b1);
    rdChk(OFF_CLAMP_REF, 32'd40, "copied");
    waitLvl(2, 1'b0);
    waitLvl(2, 1'b1);
    waitLvl(2, 1'b0);
    chk(n, 32'd41, "clamp width");
    // Huge edge delays, loaded at an A rise, keep both off
    xfer(1'b1, OFF_RISE_DLY, 32'hffff);
    xfer(1'b1, OFF_FALL_DLY, 32'hffff);
    waitLvl(0, 1'b0);
    waitLvl(0, 1'b1);
    quiet("sw off");
    // Load mode first, so zeroed delays cannot reload while still enabled
    xfer(1'b1, OFF_CTRL, 32'h3);
    xfer(1'b1, OFF_RISE_DLY, 32'h0);
    xfer(1'b1, OFF_FALL_DLY, 32'h0);
    quiet("light load");
    heavy <= 1'b1;
    waitLvl(2, 1'b1);
    chk({31'h0, n < 260}, 32'h1, "heavy on");
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk({31'h0, rd[1]}, 32'h1, "load status");
    clkEn <= 1'b0;
    repeat (6) @(posedge clk);
    clkEn <= 1'b1;
    @(posedge clk);
    print_verdict();
  end
endmodule
bind srd_sr_pwm_turnoff_delay_ctrl srd_props i_srd_props (.clk, .rst, .clkEn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hrdata, .hresp, .srPwmA, .srPwmB, .delayTileBus);

// ==== logic/srd_pkg.sv ====
// Constants, register map and carrier types for the SR turn-off delay controller
package srd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_DELAY     = 8'h04;
  localparam logic [7:0] OFF_GP_REG0   = 8'h08;
  localparam logic [7:0] OFF_SW_INPUTS = 8'h0c;
  localparam logic [7:0] OFF_RISE_DLY  = 8'h10;
  localparam logic [7:0] OFF_FALL_DLY  = 8'h14;
  localparam logic [7:0] OFF_CLAMP_REF = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1c;

  // Field positions
  localparam int SW_IN4_BIT   = 4;
  localparam int TILE_OUTS    = 8;
  localparam int BUS_OUTS     = 32;
  localparam int MIRROR_BASE  = 16;
  localparam int CNT_W        = 16;

  // Timing: 125 MHz logic clock
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int TURNOFF_DELAY_NS = 200;
  localparam int TURNOFF_DELAY_CYC = (TURNOFF_DELAY_NS * 1000) / CLK_PERIOD_PS;

  // Reset values
  localparam logic [3:0]       CTRL_RST      = 4'h9;
  localparam logic [CNT_W-1:0] DELAY_RST     = CNT_W'(TURNOFF_DELAY_CYC);
  localparam logic [CNT_W-1:0] CLAMP_RST     = 16'h0100;
  localparam logic [CNT_W-1:0] EDGE_DLY_RST  = 16'h0000;
  localparam logic [7:0]       SW_INPUTS_RST = 8'h10;

  // Control register fields, bit 3 downward
  typedef struct packed {
    logic delayEnable;
    logic singleCounter;
    logic hwLoadMode;
    logic swEnable;
  } srd_ctrl_t;

  // Per-channel event carrier
  typedef struct packed {
    logic rise;
    logic fall;
    logic offEvt;
    logic clampMatch;
  } srd_evt_t;

  // Bus data phase, Gray along idle-write path; idle to read wait flips both bits
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_RWAIT = 2'b11,
    BUS_RDONE = 2'b10
  } srd_bus_t;

endpackage

// ==== logic/srd_sr_pwm_turnoff_delay_ctrl.sv ====
// SR PWM shaping: turn-off delay, load enable, clamp update, AHB-Lite registers
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module srd_sr_pwm_turnoff_delay_ctrl
  import srd_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clkEn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  input  wire logic         primaryPwmA,
  input  wire logic         primaryPwmB,
  input  wire logic         loadCompareEvent,
  output logic              srPwmA,
  output logic              srPwmB,
  output logic [BUS_OUTS-1:0] delayTileBus
);

  // Counter step shared by every counter: clear wins, then count up while run is high
  function automatic logic [CNT_W-1:0] cntStep(input logic clr, input logic run,
                                               input logic [CNT_W-1:0] cnt);
    if (clr) begin
      return '0;
    end
    if (run) begin
      return cnt + 16'h0001;
    end
    return cnt;
  endfunction

  // Register state
  srd_ctrl_t        ctrl_q;
  logic [CNT_W-1:0] delay_q;
  logic [CNT_W-1:0] gpReg0_q;
  logic [7:0]       swInputs_q;
  logic [CNT_W-1:0] riseDly_q;
  logic [CNT_W-1:0] fallDly_q;
  logic [CNT_W-1:0] clampRef_q;
  srd_bus_t         busSt_q;
  srd_bus_t         busSt_d;
  logic [7:0]       addr_q;
  logic [31:0]      rdata_q;

  // Datapath state
  logic [1:0]       pwmIn;
  logic [1:0]       pwmPrev_q;
  srd_evt_t [1:0]   evt;

  // Clamp counters, one per channel
  logic [CNT_W-1:0] clampCnt_q  [2];
  logic [1:0]       clampRun_q;

  // Separate-tile delay counters and their match pulses
  logic [CNT_W-1:0] sepCnt_q    [2];
  logic [1:0]       sepRun_q;
  logic [1:0]       sepMatch;

  // Shared single delay counter
  logic [CNT_W-1:0] shCnt_q;
  logic             shRun_q;
  logic             shMatch;

  // Delay tile outputs
  logic [TILE_OUTS-1:0] delayOut_q;

  // SR state and turn-on stage
  logic [1:0]       srState_q;
  logic [1:0]       srState_d;
  logic [CNT_W-1:0] onCnt_q     [2];
  logic [CNT_W-1:0] actDly_q    [2];
  logic [1:0]       onReached;
  logic [1:0]       srOut_q;

  // Enable and copy control
  logic             srOn;
  logic             counter0Zero;
  logic             copyTrigger;

  // Bus decode
  wire         accept  = hsel && htrans[1] && hready;

  // Write strobes, one per writable register
  wire         wrPhase = (busSt_q == BUS_WRITE);
  wire         wrCtrl  = wrPhase && (addr_q == OFF_CTRL);
  wire         wrDelay = wrPhase && (addr_q == OFF_DELAY);
  wire         wrGp0   = wrPhase && (addr_q == OFF_GP_REG0);
  wire         wrSwIn  = wrPhase && (addr_q == OFF_SW_INPUTS);
  wire         wrRise  = wrPhase && (addr_q == OFF_RISE_DLY);
  wire         wrFall  = wrPhase && (addr_q == OFF_FALL_DLY);

  // Status word fields, bit 5 downward
  wire [5:0]   statusBits = {srOut_q, srState_q, loadCompareEvent, srOn};

  // Read mux; unmapped offsets read zero
  logic [31:0] rdMux;
  always_comb begin
    unique case (addr_q)
      OFF_CTRL:      rdMux = {28'h0000000, ctrl_q};
      OFF_DELAY:     rdMux = {16'h0000, delay_q};
      OFF_GP_REG0:   rdMux = {16'h0000, gpReg0_q};
      OFF_SW_INPUTS: rdMux = {24'h000000, swInputs_q};
      OFF_RISE_DLY:  rdMux = {16'h0000, riseDly_q};
      OFF_FALL_DLY:  rdMux = {16'h0000, fallDly_q};
      OFF_CLAMP_REF: rdMux = {16'h0000, clampRef_q};
      OFF_STATUS:    rdMux = {26'h0, statusBits};
      default:       rdMux = 32'h00000000;
    endcase
  end

  // Data phase sequencing; reads take one wait so a preceding write lands first
  // A write stores at the end of its data phase, so it needs no wait
  always_comb begin
    unique case (busSt_q)
      BUS_RWAIT: busSt_d = BUS_RDONE;
      default:   busSt_d = accept ? (hwrite ? BUS_WRITE : BUS_RWAIT) : BUS_IDLE;
    endcase
  end

  // Only the read wait stalls the bus; the answer is always OKAY
  assign hreadyout = (busSt_q != BUS_RWAIT);
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // Bus phase registers
  // Only the low byte is decoded, so offsets alias above it
  always_ff @(posedge clk) begin
    if (rst) begin
      busSt_q <= BUS_IDLE;
      addr_q  <= 8'h00;
      rdata_q <= 32'h00000000;
    end else if (clkEn) begin
      busSt_q <= busSt_d;
      if (accept) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
      if (busSt_q == BUS_RWAIT) begin
        rdata_q <= rdMux;
      end
    end
  end

  // Software-written registers
  // Clamp reference is not here: only the gated copy may move it
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q     <= CTRL_RST;
      delay_q    <= DELAY_RST;
      gpReg0_q   <= CLAMP_RST;
      swInputs_q <= SW_INPUTS_RST;
      riseDly_q  <= EDGE_DLY_RST;
      fallDly_q  <= EDGE_DLY_RST;
    end else if (clkEn) begin
      if (wrCtrl) begin
        ctrl_q <= srd_ctrl_t'(hwdata[3:0]);
      end
      if (wrDelay) begin
        delay_q <= hwdata[CNT_W-1:0];
      end
      if (wrGp0) begin
        gpReg0_q <= hwdata[CNT_W-1:0];
      end
      if (wrSwIn) begin
        swInputs_q <= hwdata[7:0];
      end
      if (wrRise) begin
        riseDly_q <= hwdata[CNT_W-1:0];
      end
      if (wrFall) begin
        fallDly_q <= hwdata[CNT_W-1:0];
      end
    end
  end

  // Primary edges; primary PWM runs on this clock so no synchroniser
  assign pwmIn = {primaryPwmB, primaryPwmA};

  always_ff @(posedge clk) begin
    if (rst) begin
      pwmPrev_q <= 2'b00;
    end else if (clkEn) begin
      pwmPrev_q <= pwmIn;
    end
  end

  // Tile input 4 is the software gate bit, input 5 the load level
  wire         swGateIn = swInputs_q[SW_IN4_BIT];
  wire         loadEnIn = loadCompareEvent;

  // Counter 0 is cleared at A rise, so its zero event is that rise
  assign counter0Zero = evt[0].rise;
  // Copy gated by software input 4 so a half-written value never lands
  assign copyTrigger  = swGateIn && counter0Zero;

  // Clamp reference updates only on the aligned event
  // It has no shadow of its own, so the aligned event acts as one
  always_ff @(posedge clk) begin
    if (rst) begin
      clampRef_q <= CLAMP_RST;
    end else if (clkEn && copyTrigger) begin
      clampRef_q <= gpReg0_q;
    end
  end

  // Shared single counter, cleared by either falling edge
  // One counter serves both edges, so the delay must stay below dead time
  wire shClear = evt[0].fall || evt[1].fall;
  assign shMatch = shRun_q && (shCnt_q == delay_q) && !shClear;

  always_ff @(posedge clk) begin
    if (rst) begin
      shCnt_q <= '0;
      shRun_q <= 1'b0;
    end else if (clkEn) begin
      shCnt_q <= cntStep(shClear, shRun_q && !shMatch, shCnt_q);
      shRun_q <= shClear || (shRun_q && !shMatch);
    end
  end

  // Delay tile outputs 0 and 1, registered; upper half mirrors lower
  // Registering costs one cycle of lag but keeps the tile outputs clean
  always_ff @(posedge clk) begin
    if (rst) begin
      delayOut_q <= '0;
    end else if (clkEn) begin
      delayOut_q <= {6'h00, sepMatch};
    end
  end

  // Outputs sixteen upward repeat the low sixteen
  assign delayTileBus = {8'h00, delayOut_q, 8'h00, delayOut_q};

  // Enable source: load comparator event or software bit
  // Hardware mode trusts the comparator's own filter for hysteresis
  assign srOn = ctrl_q.hwLoadMode ? loadEnIn : ctrl_q.swEnable;

  // Per-channel edge detect, counters, state and turn-on delay
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic tileIn;
      logic lutIn0;
      logic fsm2Lut;

      // Edges against last cycle's sample, each one cycle long
      assign evt[ch].rise = pwmIn[ch] && !pwmPrev_q[ch];
      assign evt[ch].fall = !pwmIn[ch] && pwmPrev_q[ch];

      // Channel 0 holds counter 0, channel 1 counter 1
      // Clamp counter starts at rise, match at clamp reference
      assign evt[ch].clampMatch = clampRun_q[ch] && (clampCnt_q[ch] == clampRef_q)
                                  && !evt[ch].rise;

      always_ff @(posedge clk) begin
        if (rst) begin
          clampCnt_q[ch] <= '0;
          clampRun_q[ch] <= 1'b0;
        end else if (clkEn) begin
          clampCnt_q[ch] <= cntStep(evt[ch].rise, clampRun_q[ch], clampCnt_q[ch]);
          clampRun_q[ch] <= evt[ch].rise || (clampRun_q[ch] && !evt[ch].clampMatch);
        end
      end

      // Separate-tile delay counter: zero on falling edge, match at delay
      assign sepMatch[ch] = sepRun_q[ch] && (sepCnt_q[ch] == delay_q)
                            && !evt[ch].fall;

      always_ff @(posedge clk) begin
        if (rst) begin
          sepCnt_q[ch] <= '0;
          sepRun_q[ch] <= 1'b0;
        end else if (clkEn) begin
          sepCnt_q[ch] <= cntStep(evt[ch].fall, sepRun_q[ch] && !sepMatch[ch], sepCnt_q[ch]);
          sepRun_q[ch] <= evt[ch].fall || (sepRun_q[ch] && !sepMatch[ch]);
        end
      end

      // SR tile inputs 0 and 2 select mirrored delay outputs 16 and 17
      assign tileIn = delayTileBus[MIRROR_BASE + ch];

      // Turn-off source: raw edge, separate tile, or shared counter
      assign lutIn0 = !ctrl_q.delayEnable ? evt[ch].fall
                    : (ctrl_q.singleCounter ? shMatch : tileIn);
      assign evt[ch].offEvt = lutIn0;

      // With all tables busy, the spare machine forms the off OR
      assign fsm2Lut = evt[ch].offEvt || evt[ch].clampMatch;

      // State bit: set on rise, clear on off event or clamp match
      // Rise and off event together flip the bit
      assign srState_d[ch] = (!srState_q[ch] && evt[ch].rise)
                           || (srState_q[ch] && !fsm2Lut);

      always_ff @(posedge clk) begin
        if (rst) begin
          srState_q[ch] <= 1'b0;
        end else if (clkEn) begin
          srState_q[ch] <= srState_d[ch];
        end
      end

      // Edge delays are shadowed and loaded at the period start
      // A mid-period load could cut a pulse short, hence the wait
      always_ff @(posedge clk) begin
        if (rst) begin
          actDly_q[ch] <= EDGE_DLY_RST;
        end else if (clkEn && counter0Zero) begin
          actDly_q[ch] <= (ch == 0) ? riseDly_q : fallDly_q;
        end
      end

      // Turn-on delay; a delay beyond the period keeps the output off whole pulses
      assign onReached[ch] = (onCnt_q[ch] >= actDly_q[ch]);

      always_ff @(posedge clk) begin
        if (rst) begin
          onCnt_q[ch] <= '0;
        end else if (clkEn) begin
          onCnt_q[ch] <= cntStep(!srState_q[ch], !onReached[ch], onCnt_q[ch]);
        end
      end

      // Final drive, gated by the load or software enable
      // The enable acts at the next edge, whatever the pulse phase
      always_ff @(posedge clk) begin
        if (rst) begin
          srOut_q[ch] <= 1'b0;
        end else if (clkEn) begin
          srOut_q[ch] <= srState_q[ch] && onReached[ch] && srOn;
        end
      end
    end
  endgenerate

  // Drive pins
  assign srPwmA = srOut_q[0];
  assign srPwmB = srOut_q[1];

endmodule
